/* File: hdl/hemf_consts.vh */
// Purpose: Constants for the command handler, event mask and event filter block
// Assumes: Plain Verilog-2005, included by bare name
`ifndef HEMF_CONSTS_VH
`define HEMF_CONSTS_VH

`define HEMF_OCF_SET_MASK 10'h001
`define HEMF_OCF_RESET 10'h003
`define HEMF_OCF_SET_FILTER 10'h005
`define HEMF_OGF_BASEBAND 6'h03

`define HEMF_MASK_DEFAULT 64'h00000000FFFFFFFF
`define HEMF_MASK_DEFINED 64'h00000000FFFFFFFF

`define HEMF_EVT_CONN_COMPLETE 8'h03
`define HEMF_EVT_CONN_REQUEST 8'h04
`define HEMF_EVT_INQ_RESULT 8'h02
`define HEMF_EVT_CMD_COMPLETE 8'h0E
`define HEMF_EVT_CMD_STATUS 8'h0F
`define HEMF_EVT_NUM_COMPLETED 8'h13

`define HEMF_FT_CLEAR_ALL 8'h00
`define HEMF_FT_INQUIRY 8'h01
`define HEMF_FT_CONN_SETUP 8'h02

`define HEMF_CT_ALL 8'h00
`define HEMF_CT_CLASS 8'h01
`define HEMF_CT_ADDR 8'h02

`define HEMF_ST_SUCCESS 8'h00
`define HEMF_ST_UNKNOWN_CMD 8'h01
`define HEMF_ST_MEMORY_FULL 8'h07
`define HEMF_ST_INVALID_PARAM 8'h12

// Entry layout: valid, category(2), kind(2), auto accept, class(24), class mask(24), address(48)
`define HEMF_ENTRY_W 102

// Register-port map
`define HEMF_REG_MASK_LO 4'h0
`define HEMF_REG_MASK_HI 4'h1
`define HEMF_REG_FCOUNT 4'h2
`define HEMF_REG_STATE 4'h3

`endif

/* File: hdl/hemf_filter_mem.v */
// Purpose: Filter entry store with registered read port
// Assumes: One write port, one read port, single clock
// Notes: Read data appear one cycle after the read address
module hemf_filter_mem #(
    parameter DEPTH = 8,
    parameter AW = 3,
    parameter W = 102
) (
    input wire clock,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [W-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [W-1:0] rd_data
);
    reg [W-1:0] mem [0:DEPTH-1];

    always @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // hemf_filter_mem

/* File: hdl/hemf_top.v */
// Purpose: Command interpreter for event mask, reset and event filter commands
// Assumes: Commands arrive already parsed, held with their fields until taken while cmd_ready is high
// Notes: Events are offered one at a time; ev_ready low means the block is busy
`include "hemf_consts.vh"
module hemf_top #(
    parameter DEPTH = 8,
    parameter AW = 3
) (
    clock,
    rst_b,
    cmd_valid,
    cmd_ogf,
    cmd_opcode_command_field,
    cmd_mask,
    cmd_filter_type,
    cmd_cond_type,
    cmd_class,
    cmd_class_mask,
    cmd_device_hw_address,
    cmd_auto_accept,
    cmd_ready,
    ev_valid,
    ev_code,
    ev_class,
    ev_device_hw_address,
    ev_new_device,
    ev_ready,
    out_valid,
    out_code,
    out_auto_accept,
    cc_valid,
    cc_opcode_command_field,
    cc_status,
    ctrl_reset,
    standby,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata
);
    input wire clock;
    input wire rst_b;
    input wire cmd_valid;
    input wire [5:0] cmd_ogf;
    input wire [9:0] cmd_opcode_command_field;
    input wire [63:0] cmd_mask;
    input wire [7:0] cmd_filter_type;
    input wire [7:0] cmd_cond_type;
    input wire [23:0] cmd_class;
    input wire [23:0] cmd_class_mask;
    input wire [47:0] cmd_device_hw_address;
    input wire cmd_auto_accept;
    output reg cmd_ready;
    input wire ev_valid;
    input wire [7:0] ev_code;
    input wire [23:0] ev_class;
    input wire [47:0] ev_device_hw_address;
    input wire ev_new_device;
    output reg ev_ready;
    output reg out_valid;
    output reg [7:0] out_code;
    output reg out_auto_accept;
    output reg cc_valid;
    output reg [9:0] cc_opcode_command_field;
    output reg [7:0] cc_status;
    output reg ctrl_reset;
    output reg standby;
    input wire [3:0] reg_addr;
    input wire [31:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [31:0] reg_rdata;

    localparam S_IDLE = 4'b0001;
    localparam S_SCAN = 4'b0010;
    localparam S_RESET = 4'b0100;
    localparam S_CLEAR = 4'b1000;

    reg rst_s1_r;
    reg rst_s2_r;
    wire rst_n = rst_s2_r;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    reg [3:0] state_r;
    reg [63:0] mask_r;
    reg [DEPTH-1:0] valid_r;
    reg [AW:0] count_r;
    reg [AW-1:0] scan_r;
    reg [AW-1:0] clr_r;
    reg hit_r;
    reg hit_auto_r;
    reg [7:0] ev_code_r;
    reg [23:0] ev_class_r;
    reg [47:0] ev_addr_r;
    reg ev_new_r;
    reg scan_wait_r;

    wire [`HEMF_ENTRY_W-1:0] rd_entry;
    wire mem_wr;
    wire [AW-1:0] mem_wa;
    wire [`HEMF_ENTRY_W-1:0] mem_wd;

    wire is_cmd = cmd_valid && cmd_ready && cmd_ogf == `HEMF_OGF_BASEBAND;
    wire do_mask = is_cmd && cmd_opcode_command_field == `HEMF_OCF_SET_MASK;
    wire do_reset = is_cmd && cmd_opcode_command_field == `HEMF_OCF_RESET;
    wire do_filt = is_cmd && cmd_opcode_command_field == `HEMF_OCF_SET_FILTER;
    wire ft_ok = cmd_filter_type == `HEMF_FT_INQUIRY || cmd_filter_type == `HEMF_FT_CONN_SETUP;
    wire ct_ok = cmd_cond_type <= `HEMF_CT_ADDR;
    wire f_clear_all = do_filt && cmd_filter_type == `HEMF_FT_CLEAR_ALL;
    // Kind zero erases one category; only nonzero kinds take a slot
    wire f_erase_cat = do_filt && ft_ok && cmd_cond_type == `HEMF_CT_ALL;
    wire f_bad = do_filt && cmd_filter_type != `HEMF_FT_CLEAR_ALL && !(ft_ok && ct_ok);
    wire f_full = do_filt && ft_ok && ct_ok && !f_erase_cat && count_r == DEPTH;
    wire f_add = do_filt && ft_ok && ct_ok && !f_erase_cat && !f_full;

    // Free slot: lowest invalid entry
    reg [AW-1:0] free_idx;
    integer fi;
    always @* begin
        free_idx = {AW{1'b0}};
        for (fi = DEPTH - 1; fi >= 0; fi = fi - 1) begin
            if (!valid_r[fi]) begin
                free_idx = fi[AW-1:0];
            end
        end
    end

    assign mem_wr = f_add;
    assign mem_wa = free_idx;
    assign mem_wd = {1'b1, cmd_filter_type[1:0], cmd_cond_type[1:0], cmd_auto_accept,
                     cmd_class, cmd_class_mask, cmd_device_hw_address};

    // Entry age: slot holding the newest filter has the highest sequence
    reg [7:0] seq_r [0:DEPTH-1];
    reg [7:0] seq_ctr_r;
    reg [7:0] best_seq_r;

    wire is_inq = ev_code == `HEMF_EVT_INQ_RESULT;
    wire is_conn = ev_code == `HEMF_EVT_CONN_COMPLETE || ev_code == `HEMF_EVT_CONN_REQUEST;
    wire always_on = ev_code == `HEMF_EVT_CMD_COMPLETE || ev_code == `HEMF_EVT_CMD_STATUS ||
                     ev_code == `HEMF_EVT_NUM_COMPLETED;
    wire [7:0] bit_idx = ev_code - 8'h01;
    wire mask_en = ev_code != 8'h00 && ev_code <= 8'h20 && mask_r[bit_idx[5:0]];

    // Category presence per type, and the slots a category erase frees
    reg [1:0] cat_r [0:DEPTH-1];
    reg has_inq;
    reg has_conn;
    reg [DEPTH-1:0] cat_sel;
    reg [AW:0] erase_cnt;
    integer hi;
    always @* begin
        has_inq = 1'b0;
        has_conn = 1'b0;
        cat_sel = {DEPTH{1'b0}};
        erase_cnt = {(AW+1){1'b0}};
        for (hi = 0; hi < DEPTH; hi = hi + 1) begin
            if (valid_r[hi] && cat_r[hi] == 2'd1) begin
                has_inq = 1'b1;
            end
            if (valid_r[hi] && cat_r[hi] == 2'd2) begin
                has_conn = 1'b1;
            end
            if (valid_r[hi] && cat_r[hi] == cmd_filter_type[1:0]) begin
                cat_sel[hi] = 1'b1;
                erase_cnt = erase_cnt + 1'b1;
            end
        end
    end

    wire [1:0] e_cat = rd_entry[100:99];
    wire [1:0] e_kind = rd_entry[98:97];
    wire e_auto = rd_entry[96];
    wire [23:0] e_class = rd_entry[95:72];
    wire [23:0] e_cmask = rd_entry[71:48];
    wire [47:0] e_addr = rd_entry[47:0];
    wire [1:0] want_cat = (ev_code_r == `HEMF_EVT_INQ_RESULT) ? 2'd1 : 2'd2;
    wire e_match = valid_r[scan_r] && e_cat == want_cat && (
                   (e_kind == 2'd0 && (want_cat == 2'd2 || ev_new_r)) ||
                   (e_kind == 2'd1 && ((ev_class_r ^ e_class) & e_cmask) == 24'h000000) ||
                   (e_kind == 2'd2 && ev_addr_r == e_addr));

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= S_CLEAR;
            mask_r <= `HEMF_MASK_DEFAULT;
            valid_r <= {DEPTH{1'b0}};
            count_r <= {(AW+1){1'b0}};
            scan_r <= {AW{1'b0}};
            clr_r <= {AW{1'b0}};
            hit_r <= 1'b0;
            hit_auto_r <= 1'b0;
            best_seq_r <= 8'h00;
            seq_ctr_r <= 8'h00;
            ev_code_r <= 8'h00;
            ev_class_r <= 24'h000000;
            ev_addr_r <= 48'h000000000000;
            ev_new_r <= 1'b0;
            scan_wait_r <= 1'b0;
            cmd_ready <= 1'b0;
            ev_ready <= 1'b0;
            out_valid <= 1'b0;
            out_code <= 8'h00;
            out_auto_accept <= 1'b0;
            cc_valid <= 1'b0;
            cc_opcode_command_field <= 10'h000;
            cc_status <= 8'h00;
            ctrl_reset <= 1'b1;
            standby <= 1'b0;
        end else begin
            out_valid <= 1'b0;
            cc_valid <= 1'b0;
            ctrl_reset <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (is_cmd) begin
                        cc_valid <= 1'b1;
                        cc_opcode_command_field <= cmd_opcode_command_field;
                        cc_status <= `HEMF_ST_SUCCESS;
                        if (do_mask) begin
                            mask_r <= cmd_mask & `HEMF_MASK_DEFINED;
                        end else if (do_reset) begin
                            cmd_ready <= 1'b0;
                            ev_ready <= 1'b0;
                            standby <= 1'b0;
                            state_r <= S_RESET;
                        end else if (f_clear_all) begin
                            valid_r <= {DEPTH{1'b0}};
                            count_r <= {(AW+1){1'b0}};
                        end else if (f_erase_cat) begin
                            valid_r <= valid_r & ~cat_sel;
                            count_r <= count_r - erase_cnt;
                        end else if (f_full) begin
                            cc_status <= `HEMF_ST_MEMORY_FULL;
                        end else if (f_bad) begin
                            cc_status <= `HEMF_ST_INVALID_PARAM;
                        end else if (f_add) begin
                            valid_r[free_idx] <= 1'b1;
                            count_r <= count_r + 1'b1;
                            seq_ctr_r <= seq_ctr_r + 8'h01;
                        end else if (!do_filt) begin
                            cc_status <= `HEMF_ST_UNKNOWN_CMD;
                        end
                    end else if (ev_valid && ev_ready) begin
                        if (always_on) begin
                            out_valid <= 1'b1;
                            out_code <= ev_code;
                            out_auto_accept <= 1'b0;
                        end else if (mask_en && ((is_inq && has_inq) || (is_conn && has_conn))) begin
                            ev_code_r <= ev_code;
                            ev_class_r <= ev_class;
                            ev_addr_r <= ev_device_hw_address;
                            ev_new_r <= ev_new_device;
                            scan_r <= {AW{1'b0}};
                            scan_wait_r <= 1'b1;
                            hit_r <= 1'b0;
                            hit_auto_r <= 1'b0;
                            best_seq_r <= 8'h00;
                            cmd_ready <= 1'b0;
                            ev_ready <= 1'b0;
                            state_r <= S_SCAN;
                        end else if (mask_en) begin
                            out_valid <= 1'b1;
                            out_code <= ev_code;
                            out_auto_accept <= 1'b0;
                        end
                    end
                end
                S_SCAN: begin
                    scan_wait_r <= 1'b0;
                    if (!scan_wait_r) begin
                        if (e_match && (!hit_r || seq_r[scan_r] >= best_seq_r)) begin
                            hit_r <= 1'b1;
                            hit_auto_r <= e_auto;
                            best_seq_r <= seq_r[scan_r];
                        end
                        scan_wait_r <= 1'b1;
                        if (scan_r == DEPTH - 1) begin
                            state_r <= S_IDLE;
                            cmd_ready <= 1'b1;
                            ev_ready <= 1'b1;
                            if (e_match || hit_r) begin
                                out_valid <= 1'b1;
                                out_code <= ev_code_r;
                                out_auto_accept <= (e_match && (!hit_r || seq_r[scan_r] >= best_seq_r)) ?
                                                   e_auto : hit_auto_r;
                            end
                        end else begin
                            scan_r <= scan_r + 1'b1;
                        end
                    end
                end
                S_RESET: begin
                    ctrl_reset <= 1'b1;
                    mask_r <= `HEMF_MASK_DEFAULT;
                    valid_r <= {DEPTH{1'b0}};
                    count_r <= {(AW+1){1'b0}};
                    seq_ctr_r <= 8'h00;
                    out_auto_accept <= 1'b0;
                    state_r <= S_CLEAR;
                end
                S_CLEAR: begin
                    state_r <= S_IDLE;
                    cmd_ready <= 1'b1;
                    ev_ready <= 1'b1;
                    standby <= 1'b1;
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // Category and age bookkeeping per slot, written when a filter is added to that slot
    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : g_slot
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    cat_r[g] <= 2'd0;
                    seq_r[g] <= 8'h00;
                end else if (state_r == S_IDLE && f_add && free_idx == g) begin
                    cat_r[g] <= cmd_filter_type[1:0];
                    seq_r[g] <= seq_ctr_r;
                end
            end
        end
    endgenerate

    hemf_filter_mem #(
        .DEPTH(DEPTH),
        .AW(AW),
        .W(`HEMF_ENTRY_W)
    ) u_mem (
        .clock(clock),
        .wr_en(mem_wr),
        .wr_addr(mem_wa),
        .wr_data(mem_wd),
        .rd_addr(scan_r),
        .rd_data(rd_entry)
    );

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `HEMF_REG_MASK_LO: reg_rdata <= mask_r[31:0];
                `HEMF_REG_MASK_HI: reg_rdata <= mask_r[63:32];
                `HEMF_REG_FCOUNT: reg_rdata <= {{(31-AW){1'b0}}, count_r};
                `HEMF_REG_STATE: reg_rdata <= {26'h0000000, standby, 1'b0, state_r};
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule // hemf_top

/* File: tb/hemf_top_asserts.sv */
// Purpose: Port-level checker for the mask, reset and filter command block
// Assumes: Single clock domain, rst_b active low
// Notes: Keeps its own copy of the event mask from the commands it sees
module hemf_chk #(
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clock,
    input wire rst_b,
    input wire cmd_valid,
    input wire [5:0] cmd_ogf,
    input wire [9:0] cmd_opcode_command_field,
    input wire [63:0] cmd_mask,
    input wire cmd_ready,
    input wire ev_valid,
    input wire [7:0] ev_code,
    input wire ev_ready,
    input wire out_valid,
    input wire [7:0] out_code,
    input wire cc_valid,
    input wire [9:0] cc_opcode_command_field,
    input wire [7:0] cc_status,
    input wire ctrl_reset,
    input wire standby
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    reg [63:0] mask_r;
    wire cmd_t = cmd_valid && cmd_ready && cmd_ogf == 6'h03;
    wire ev_t = ev_valid && ev_ready && !cmd_t;
    wire [9:0] op = cmd_opcode_command_field;
    wire fixed_ev = ev_code == 8'h0E || ev_code == 8'h0F || ev_code == 8'h13;
    wire filt_ev = ev_code >= 8'h02 && ev_code <= 8'h04;
    wire in_range = ev_code >= 8'h01 && ev_code <= 8'h20;
    // Shadow of the mask, back to its default on any reset
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mask_r <= 64'h00000000FFFFFFFF;
        end else if (ctrl_reset) begin
            mask_r <= 64'h00000000FFFFFFFF;
        end else if (cmd_t && op == 10'h001) begin
            mask_r <= cmd_mask;
        end
    end
    a_cc_after_cmd: assert property (cmd_t |=> cc_valid && cc_opcode_command_field == $past(op))
        else $error("no command complete after command");
    a_mask_status_ok: assert property (cmd_t && op == 10'h001 |=> cc_status == 8'h00)
        else $error("mask command status not zero");
    a_unknown_op_status: assert property (cmd_t && op != 10'h001 && op != 10'h003 && op != 10'h005
        |=> cc_status == 8'h01)
        else $error("unknown command status wrong");
    a_reset_cc_first: assert property (cmd_t && op == 10'h003 |=> cc_valid && cc_status == 8'h00 ##1 ctrl_reset)
        else $error("reset not preceded by command complete");
    a_standby_after: assert property (ctrl_reset |-> ##[1:20] standby && cmd_ready)
        else $error("standby not reached after reset");
    a_fixed_events: assert property (ev_t && fixed_ev |=> out_valid && out_code == $past(ev_code))
        else $error("unmaskable event not delivered");
    a_masked_drop: assert property (ev_t && in_range && !fixed_ev && !filt_ev && !mask_r[ev_code - 8'h01]
        |=> !out_valid)
        else $error("masked event delivered");
    a_ev_done_bound: assert property (ev_t |=> ##[0:40] ev_ready)
        else $error("event handling not finished in time");
    c_reset_cmd: cover property (cmd_t && op == 10'h003);
    c_full_list: cover property (cc_valid && cc_status == 8'h07);
    c_fixed_event: cover property (ev_t && fixed_ev);
endmodule // hemf_chk

bind hemf_top hemf_chk #(.DEPTH(DEPTH), .AW(AW)) hemf_chk_inst (.clock(clock), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd_ogf(cmd_ogf), .cmd_opcode_command_field(cmd_opcode_command_field),
    .cmd_mask(cmd_mask), .cmd_ready(cmd_ready), .ev_valid(ev_valid), .ev_code(ev_code), .ev_ready(ev_ready),
    .out_valid(out_valid), .out_code(out_code), .cc_valid(cc_valid),
    .cc_opcode_command_field(cc_opcode_command_field), .cc_status(cc_status), .ctrl_reset(ctrl_reset),
    .standby(standby));

/* File: tb/hemf_host_model.sv */
// Purpose: Host side that issues commands and collects command complete
// Assumes: Command taken at the edge where cmd_ready is high
// Notes: Parameters are held until taken, then mask and address are driven to their inverse
module hemf_host_model (
    input wire clock,
    input wire cmd_ready,
    input wire cc_valid,
    input wire [7:0] cc_status,
    output logic cmd_valid,
    output logic [5:0] cmd_ogf,
    output logic [9:0] cmd_opcode_command_field,
    output logic [63:0] cmd_mask,
    output logic [7:0] cmd_filter_type,
    output logic [7:0] cmd_cond_type,
    output logic [23:0] cmd_class,
    output logic [23:0] cmd_class_mask,
    output logic [47:0] cmd_device_hw_address,
    output logic cmd_auto_accept
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cmd_valid, cmd_ogf, cmd_opcode_command_field, cmd_mask, cmd_filter_type, cmd_cond_type} = '0;
        {cmd_class, cmd_class_mask, cmd_device_hw_address, cmd_auto_accept} = '0;
    end
    task automatic send(input [9:0] op, input [63:0] m, input [7:0] ft, input [7:0] ct, input [23:0] cls,
        input [47:0] adr, input aa, output logic [7:0] st);
        int n;
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_ogf <= 6'h03;
        cmd_opcode_command_field <= op;
        cmd_mask <= m;
        {cmd_filter_type, cmd_cond_type, cmd_class, cmd_class_mask} <= {ft, ct, cls, 24'hFFFFFF};
        {cmd_device_hw_address, cmd_auto_accept} <= {adr, aa};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (cmd_ready !== 1'b1 && n < 50);
        cmd_valid <= 1'b0;
        cmd_mask <= ~m;
        cmd_device_hw_address <= ~adr;
        st = 8'hXX;
        for (n = 0; n < 4; n++) begin
            @(posedge clock);
            if (cc_valid === 1'b1) begin
                st = cc_status;
                break;
            end
        end
    endtask
endmodule // hemf_host_model

/* File: tb/hemf_top_bench.sv */
// Purpose: Directed checks of mask, reset and filter commands
// Assumes: Register port reads are one cycle late
// Notes: Filters compare full class bits and full addresses
module hemf_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rst_b = 0, ev_valid = 0, ev_new_device = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0] ev_code = 0, st, oc;
    logic [23:0] ev_class = 0;
    logic [47:0] ev_device_hw_address = 0;
    logic [3:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, rd;
    logic cmd_valid, cmd_auto_accept, cmd_ready, ev_ready, out_valid, out_auto_accept, cc_valid, ctrl_reset, standby;
    logic [5:0] cmd_ogf;
    logic [9:0] cmd_opcode_command_field, cc_opcode_command_field;
    logic [63:0] cmd_mask;
    logic [7:0] cmd_filter_type, cmd_cond_type, out_code, cc_status;
    logic [23:0] cmd_class, cmd_class_mask;
    logic [47:0] cmd_device_hw_address;
    logic [31:0] reg_rdata;
    logic seen, aa;
    int mismatches = 0, checks = 0, cyc = 0, i;
    localparam [47:0] ADR_A = 48'h0000_1234_5678, ADR_B = 48'h0000_9ABC_DEF0;
    always #2 clock = ~clock;
    hemf_top #(.DEPTH(8), .AW(3)) hemf_top_inst (.*);
    hemf_host_model hemf_host_model_inst (.*);
    task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc > 6000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic rreg(input [3:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        d = reg_rdata;
    endtask
    task automatic wreg(input [3:0] a, input [31:0] d);
        @(posedge clock);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic cmd(input [9:0] op, input [63:0] m, input [7:0] ft, ct, input [47:0] adr, input a);
        hemf_host_model_inst.send(op, m, ft, ct, 24'h5A0104, adr, a, st);
    endtask
    // Offers one event and waits for it to be forwarded or dropped
    task automatic ev(input [7:0] c, input [47:0] adr, input [23:0] cls);
        int n;
        @(posedge clock);
        {ev_valid, ev_code, ev_device_hw_address, ev_class, ev_new_device} <= {1'b1, c, adr, cls, 1'b0};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (ev_ready !== 1'b1 && n < 50);
        ev_valid <= 1'b0;
        ev_code <= ~c;
        seen = 0;
        for (n = 0; n < 40 && !seen; n++) begin
            @(posedge clock);
            if (out_valid === 1'b1) {seen, oc, aa} = {1'b1, out_code, out_auto_accept};
        end
    endtask
    task automatic wait_ready;
        for (i = 0; i < 40 && !(standby === 1'b1 && cmd_ready === 1'b1); i++) @(posedge clock);
    endtask
    initial begin
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        wait_ready();
        chk("standby", standby, 1);
        rreg(4'h0, rd); chk("mask_lo", rd, 32'hFFFFFFFF);
        rreg(4'h1, rd); chk("mask_hi", rd, 0);
        rreg(4'h2, rd); chk("fcount", rd, 0);
        wreg(4'h0, 32'h0000_0000);
        rreg(4'h0, rd); chk("mask_ro", rd, 32'hFFFFFFFF);
        rreg(4'hF, rd);
        cmd(10'h002, 0, 0, 0, 0, 0); chk("unknown_st", st, 8'h01);
        cmd(10'h001, 64'h10, 0, 0, 0, 0); chk("mask_st", st, 8'h00);
        rreg(4'h0, rd); chk("mask_new", rd, 32'h10);
        ev(8'h05, 0, 0); chk("ev_on", {seen, oc}, {1'b1, 8'h05});
        ev(8'h06, 0, 0); chk("ev_off", seen, 0);
        ev(8'h0E, 0, 0); chk("ev_cc", {seen, oc}, {1'b1, 8'h0E});
        ev(8'h0F, 0, 0); chk("ev_cs", {seen, oc}, {1'b1, 8'h0F});
        ev(8'h13, 0, 0); chk("ev_ncp", {seen, oc}, {1'b1, 8'h13});
        cmd(10'h001, 64'hFFFFFFFF, 0, 0, 0, 0);
        cmd(10'h005, 0, 8'h01, 8'h02, ADR_A, 0); chk("flt_st", st, 0);
        ev(8'h02, ADR_A, 0); chk("inq_hit", seen, 1);
        ev(8'h02, ADR_B, 0); chk("inq_miss", seen, 0);
        cmd(10'h005, 0, 8'h01, 8'h01, 0, 0);
        ev(8'h02, ADR_B, 24'h5A0104); chk("inq_cls", seen, 1);
        ev(8'h02, ADR_A, 0); chk("inq_keep", seen, 1);
        cmd(10'h005, 0, 8'h02, 8'h02, ADR_A, 0);
        cmd(10'h005, 0, 8'h02, 8'h02, ADR_A, 1);
        ev(8'h04, ADR_A, 0); chk("conn_new", {seen, aa}, 2'b11);
        ev(8'h04, ADR_B, 0); chk("conn_miss", seen, 0);
        for (i = 0; i < 4; i++) cmd(10'h005, 0, 8'h01, 8'h02, ADR_B + i, 0);
        rreg(4'h2, rd); chk("fcount_full", rd, 8);
        cmd(10'h005, 0, 8'h01, 8'h02, ADR_B, 0); chk("full_st", st, 8'h07);
        rreg(4'h2, rd); chk("fcount_kept", rd, 8);
        cmd(10'h005, 0, 8'h02, 8'h00, 0, 0); chk("erase_st", st, 0);
        rreg(4'h2, rd); chk("fcount_cat", rd, 6);
        ev(8'h04, ADR_B, 0); chk("conn_open", {seen, aa}, 2'b10);
        ev(8'h02, ADR_A, 0); chk("inq_left", seen, 1);
        cmd(10'h005, 0, 8'h00, 0, 0, 0); chk("clr_st", st, 0);
        rreg(4'h2, rd); chk("fcount_clr", rd, 0);
        ev(8'h04, ADR_B, 0); chk("conn_free", {seen, aa}, 2'b10);
        cmd(10'h001, 64'h4, 0, 0, 0, 0);
        cmd(10'h005, 0, 8'h01, 8'h02, ADR_A, 0);
        cmd(10'h003, 0, 0, 0, 0, 0); chk("rst_st", st, 0);
        wait_ready();
        rreg(4'h0, rd); chk("mask_dflt", rd, 32'hFFFFFFFF);
        rreg(4'h2, rd); chk("fcount_dflt", rd, 0);
        ev(8'h02, ADR_B, 0); chk("inq_open", seen, 1);
        tally_and_finish();
    end
endmodule // hemf_top_bench
